// *** efc_evt_model.sv ***
// Purpose: System event source standing in for the event producers
// Assumes: One event is fired at a time, by a one-cycle request
// Notes:   Lines are idle low; a fired line stays high four cycles
`timescale 1ns/10ps
module efc_evt_model (
	input  wire logic         mclk,
	input  wire logic         fire,
	input  wire logic [6:0]   idx,
	output logic      [127:0] sys_event
);
	logic [6:0] held_idx = 7'h0;
	logic [2:0] left     = 3'h0;

	// Holds the line long enough to pass the two-stage synchroniser
	always_ff @(posedge mclk)
	begin
		if (fire)
		begin
			held_idx <= idx;
			left     <= 3'h4;
		end
		else if (left != 3'h0)
			left <= left - 3'h1;
	end

	// Event number selects the line
	assign sys_event = (left != 3'h0) ? (128'h1 << held_idx) : 128'h0;
endmodule

// *** efc_group.sv ***
// Purpose: One 32-bit group of event flags with combine logic
// Assumes: Events are synchronised, clear and set are one-cycle strobes
// Notes:   Event arrival beats a simultaneous clear
`timescale 1ns/10ps
module efc_group #(
	parameter logic [31:0] HOLE = 32'h00000000
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [31:0] event_in,
	input  wire logic [31:0] clear_bit,
	input  wire logic [31:0] force_bit,
	input  wire logic [31:0] exclude_bit,
	output logic      [31:0] event_latch_regs,
	output logic             combined
);
	logic [31:0] next_latch;
	logic [31:0] hits;

	// Flag next state: hold, clear on one, set by event or force
	always_comb
	begin
		hits       = (event_in | force_bit) & ~HOLE;
		next_latch = ((event_latch_regs & ~clear_bit) | hits);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			event_latch_regs <= efc_pkg::LATCH_RESET;
			combined         <= 1'b0;
		end
		else
		begin
			event_latch_regs <= next_latch;
			// OR of unmasked flags, holes always masked
			combined <= |(next_latch & ~exclude_bit & ~HOLE);
		end
	end

	a_event_wins_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		(event_in[6] && clear_bit[6]) |=> event_latch_regs[6])
		else $error("event lost against clear");
	a_flag_holds: assert property (@(posedge mclk) disable iff (!rst_n)
		(event_latch_regs[5] && !clear_bit[5]) |=> event_latch_regs[5])
		else $error("flag dropped without clear");
	a_clear_drops: assert property (@(posedge mclk) disable iff (!rst_n)
		(clear_bit[5] && !event_in[5] && !force_bit[5]) |=> !event_latch_regs[5])
		else $error("clear did not clear flag");
	a_force_sets: assert property (@(posedge mclk) disable iff (!rst_n)
		(force_bit[7] && !HOLE[7]) |=> event_latch_regs[7])
		else $error("force did not set flag");
	a_hole_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		(event_latch_regs & HOLE) == 32'h00000000)
		else $error("reserved flag set");
	a_combine_level: assert property (@(posedge mclk) disable iff (!rst_n)
		combined == |(event_latch_regs & ~$past(exclude_bit) & ~HOLE))
		else $error("combined event wrong");
endmodule

// *** efc_pkg.sv ***
// Purpose: Constants for the event flag combiner
// Assumes: AXI4-Lite register port, 32-bit data, word aligned
// Notes:   Offsets are byte addresses within the block
package efc_pkg;
	localparam int unsigned NUM_GROUPS   = 4;
	localparam int unsigned WORD_BITS    = 32;
	localparam int unsigned NUM_EVENTS   = 128;
	localparam int unsigned ADDR_BITS    = 8;
	// Register byte offsets; each group register is at base + 4 * group
	localparam logic [7:0] OFS_LATCH     = 8'h00;
	localparam logic [7:0] OFS_CLEAR     = 8'h10;
	localparam logic [7:0] OFS_SET       = 8'h20;
	localparam logic [7:0] OFS_MASK      = 8'h30;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h44;
	// Reset values
	localparam logic [31:0] MASK_RESET   = 32'h00000000;
	localparam logic [31:0] LATCH_RESET  = 32'h00000000;
	localparam logic [3:0]  IRQ_RESET    = 4'h0;
	// Positions 0..3 of group 0 have no event and are always masked
	localparam logic [31:0] GROUP0_HOLE  = 32'h0000000F;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

// *** efc_sync.sv ***
// Purpose: Two-stage synchroniser for a vector of levels
// Assumes: Inputs come from outside the mclk domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module efc_sync #(
	parameter int unsigned WIDTH = 128
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// Two flops in series
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1   <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// *** efc_top.sv ***
// Purpose: Event flag combiner with AXI4-Lite register port
// Assumes: 124 raw events arrive asynchronously as levels or pulses
// Notes:   Combined events feed an external interrupt selector
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
// Operation
// - Each flag latches to one on its event and holds until cleared by software.
// - Flag registers are read-only and writes to them change nothing.
// - Four write-only 32-bit clear registers map bit for bit onto the flags.
// - Writing a one to a clear bit resets the matching flag.
// - Four write-only 32-bit set registers map bit for bit onto the flags.
// - Writing a one to a set bit sets the matching flag like an event.
// - An event in the same cycle as a clear leaves the flag set.
// - Each combined event is the OR of the unmasked flags of its group.
// - Groups cover events 4-31, 32-63, 64-95 and 96-127.
// - Combined events appear as numbers 0 to 3 beside the 124 raw events.
// - One read/write 32-bit mask per group resets to zero.
// - Positions 0 to 3 of the first group are always masked.
// - Flags 0 to 3 of the first group have no input and read zero.
// - Each raw event maps to the flag bit indexed by its event number.
module efc_top (
	input  wire logic         mclk,
	input  wire logic         resetn,
	input  wire logic [127:0] sys_event,
	output logic      [127:0] selector_events,
	output logic              irq,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready
);
	logic         rst_meta;
	logic         rst_n;
	logic [127:0] event_sync;
	logic [31:0]  latch   [4];
	logic [31:0]  mask    [4];
	logic [31:0]  clr_stb [4];
	logic [31:0]  set_stb [4];
	logic [3:0]   combined;
	logic [3:0]   irq_stat;
	logic [3:0]   irq_mask;
	logic [3:0]   prev_comb;
	logic         aw_held;
	logic         w_held;
	logic [7:0]   aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;
	logic         do_write;
	logic [31:0]  wmask;
	logic [1:0]   wgrp;
	logic [7:0]   wbase;

	logic         next_aw_held;
	logic         next_w_held;
	logic [7:0]   next_aw_addr;
	logic [31:0]  next_w_data;
	logic [3:0]   next_w_strb;
	logic         next_bvalid;
	logic [1:0]   next_bresp;
	logic         next_rvalid;
	logic [31:0]  next_rdata;
	logic [1:0]   next_rresp;
	logic [31:0]  next_mask [4];
	logic [3:0]   next_irq_stat;
	logic [3:0]   next_irq_mask;
	logic [3:0]   rise;

	// Reset release through two flops
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Raw events cross into mclk
	efc_sync #(.WIDTH(128)) u_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in (sys_event),
		.sync_out (event_sync)
	);

	// One flag group per 32 events, index equals event number
	for (genvar g = 0; g < 4; g++)
	begin : g_grp
		efc_group #(.HOLE(g == 0 ? efc_pkg::GROUP0_HOLE : 32'h00000000)) u_grp (
			.mclk             (mclk),
			.rst_n            (rst_n),
			.event_in         (event_sync[g*32 +: 32]),
			.clear_bit        (clr_stb[g]),
			.force_bit        (set_stb[g]),
			.exclude_bit      (mask[g]),
			.event_latch_regs (latch[g]),
			.combined         (combined[g])
		);
	end

	// Write decode: byte-lane mask, group index and register base
	always_comb
	begin
		do_write = aw_held && w_held && !s_axi_bvalid;
		wgrp     = aw_addr[3:2];
		wbase    = {aw_addr[7:4], 4'h0};
		for (int b = 0; b < 4; b++)
		begin
			wmask[b*8 +: 8] = {8{w_strb[b]}};
		end
	end

	// Clear and set strobes, one cycle per write
	always_comb
	begin
		for (int g = 0; g < 4; g++)
		begin
			clr_stb[g] = '0;
			set_stb[g] = '0;
			if (do_write && wgrp == 2'(g))
			begin
				if (wbase == efc_pkg::OFS_CLEAR)
					clr_stb[g] = w_data & wmask;
				if (wbase == efc_pkg::OFS_SET)
					set_stb[g] = w_data & wmask;
			end
		end
	end

	// AXI channel capture, register writes and reads
	always_comb
	begin
		next_aw_held  = aw_held;
		next_w_held   = w_held;
		next_aw_addr  = aw_addr;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_bvalid   = s_axi_bvalid && !s_axi_bready;
		next_bresp    = s_axi_bresp;
		next_rvalid   = s_axi_rvalid && !s_axi_rready;
		next_rdata    = s_axi_rdata;
		next_rresp    = s_axi_rresp;
		next_irq_mask = irq_mask;
		for (int g = 0; g < 4; g++)
			next_mask[g] = mask[g];
		rise          = combined & ~prev_comb;
		next_irq_stat = irq_stat;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write)
		begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = efc_pkg::RESP_OKAY;
			unique case (wbase)
				efc_pkg::OFS_LATCH: ;
				efc_pkg::OFS_CLEAR: ;
				efc_pkg::OFS_SET: ;
				efc_pkg::OFS_MASK:
					next_mask[wgrp] = (w_data & wmask) | (mask[wgrp] & ~wmask);
				efc_pkg::OFS_IRQ_STAT:
				begin
					if (wgrp == 2'h0)
						next_irq_stat = irq_stat & ~(w_data[3:0] & wmask[3:0]);
					else if (wgrp == 2'h1)
						next_irq_mask = (w_data[3:0] & wmask[3:0]) | (irq_mask & ~wmask[3:0]);
					else
						next_bresp = efc_pkg::RESP_SLVERR;
				end
				default:
					next_bresp = efc_pkg::RESP_SLVERR;
			endcase
		end
		// Sticky status on each combined event rise; set beats clear
		next_irq_stat = next_irq_stat | rise;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = efc_pkg::RESP_OKAY;
			next_rdata  = 32'h00000000;
			unique case ({s_axi_araddr[7:4], 4'h0})
				efc_pkg::OFS_LATCH:
					next_rdata = latch[s_axi_araddr[3:2]];
				efc_pkg::OFS_CLEAR: ;
				efc_pkg::OFS_SET: ;
				efc_pkg::OFS_MASK:
					next_rdata = mask[s_axi_araddr[3:2]];
				efc_pkg::OFS_IRQ_STAT:
				begin
					if (s_axi_araddr[3:2] == 2'h0)
						next_rdata = {28'h0000000, irq_stat};
					else if (s_axi_araddr[3:2] == 2'h1)
						next_rdata = {28'h0000000, irq_mask};
					else
						next_rresp = efc_pkg::RESP_SLVERR;
				end
				default:
					next_rresp = efc_pkg::RESP_SLVERR;
			endcase
		end
	end

	// Register all bus, mask and interrupt state
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= efc_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= efc_pkg::RESP_OKAY;
			irq_stat     <= efc_pkg::IRQ_RESET;
			irq_mask     <= efc_pkg::IRQ_RESET;
			prev_comb    <= 4'h0;
			for (int g = 0; g < 4; g++)
				mask[g] <= efc_pkg::MASK_RESET;
		end
		else
		begin
			aw_held      <= next_aw_held;
			w_held       <= next_w_held;
			aw_addr      <= next_aw_addr;
			w_data       <= next_w_data;
			w_strb       <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
			irq_stat     <= next_irq_stat;
			irq_mask     <= next_irq_mask;
			prev_comb    <= combined;
			for (int g = 0; g < 4; g++)
				mask[g] <= next_mask[g];
		end
	end

	// Ready outputs, interrupt and selector vector all from flops
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready   <= 1'b0;
			s_axi_wready    <= 1'b0;
			s_axi_arready   <= 1'b0;
			irq             <= 1'b0;
			selector_events <= '0;
		end
		else
		begin
			s_axi_awready   <= !next_aw_held && !next_bvalid;
			s_axi_wready    <= !next_w_held && !next_bvalid;
			s_axi_arready   <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
			irq             <= |(next_irq_stat & irq_mask);
			selector_events <= {event_sync[127:4], combined};
		end
	end

	a_read_one_out: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("read data changed while pending");
	a_mask_reset_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(rst_n) |-> ({mask[0], mask[1], mask[2], mask[3]} == 128'h0))
		else $error("mask not zero after reset");
	a_selector_map: assert property (@(posedge mclk) disable iff (!rst_n)
		selector_events[3:0] == $past(combined))
		else $error("combined events not on numbers 0 to 3");
endmodule

// *** tb_top.sv ***
// Purpose: Self-checking bench for the event flag combiner
// Assumes: Registered AXI4-Lite answers; flags settle within eight cycles
// Notes:   Handshakes are sampled at the falling edge before each rise
`timescale 1ns/10ps
module tb_top;
	localparam logic [7:0] L0 = efc_pkg::OFS_LATCH;
	localparam logic [7:0] C0 = efc_pkg::OFS_CLEAR;
	localparam logic [7:0] S0 = efc_pkg::OFS_SET;
	localparam logic [7:0] M0 = efc_pkg::OFS_MASK;
	localparam logic [1:0] OK = efc_pkg::RESP_OKAY;
	logic         mclk, resetn, fire, irq;
	logic [6:0]   idx;
	logic [127:0] sys_event, selector_events;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready;
	int           miscompares = 0;
	int           comparisons = 0;

	efc_top efc_top_inst (.mclk, .resetn, .sys_event, .selector_events, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	efc_evt_model efc_evt_model_inst (.mclk, .fire, .idx, .sys_event);

	// Clock at 40 MHz
	initial
	begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	// Counts a comparison and reports a mismatch
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask

	// Prints the counts and the verdict, then stops
	task automatic final_report;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic hang(input string nm);
		$display("ERROR %s expected answer seen timeout", nm);
		miscompares++;
		final_report();
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
	endtask

	// One write; address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, ta, tw, got;
		int   n;
		aw = 1'h1;
		w = 1'h1;
		got = 1'h0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while ((aw || w || !got) && n < 40)
		begin
			@(negedge mclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			got = s_axi_bvalid;
			if (got)
				chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
			@(posedge mclk);
			if (aw && ta)
			begin
				aw = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w && tw)
			begin
				w = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
			n++;
		end
		s_axi_bready <= 1'h0;
		@(posedge mclk);
		if (!got)
			hang("bvalid");
	endtask

	// One read with expected data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ar, ta, got;
		int   n;
		ar = 1'h1;
		got = 1'h0;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while ((ar || !got) && n < 40)
		begin
			@(negedge mclk);
			ta = s_axi_arready;
			got = s_axi_rvalid;
			if (got)
			begin
				chk($sformatf("rdata %h", a), e, s_axi_rdata);
				chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
			end
			@(posedge mclk);
			if (ar && ta)
			begin
				ar = 1'h0;
				s_axi_arvalid <= 1'h0;
			end
			n++;
		end
		s_axi_rready <= 1'h0;
		@(posedge mclk);
		if (!got)
			hang("rvalid");
	endtask

	// Combined events and interrupt line, looked at between edges
	task automatic sel(input logic [3:0] e);
		@(negedge mclk);
		chk("combined", {28'h0, e}, {28'h0, selector_events[3:0]});
		@(posedge mclk);
	endtask

	task automatic irqchk(input logic e);
		@(negedge mclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge mclk);
	endtask

	// Fires one event and sees its raw line reach the selector
	task automatic fire_evt(input logic [6:0] i);
		fire <= 1'h1;
		idx <= i;
		@(posedge mclk);
		fire <= 1'h0;
		tick(3);
		@(negedge mclk);
		chk("raw event", 32'h1, {31'h0, selector_events[i]});
		@(posedge mclk);
		tick(4);
	endtask

	// Main sequence
	initial
	begin
		resetn = 1'h0;
		fire = 1'h0;
		idx = 7'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		tick(2);
		resetn <= 1'h1;
		tick(6);
		for (int g = 0; g < 4; g++)
		begin
			rd(M0 + 8'(4 * g), efc_pkg::MASK_RESET, OK);
			rd(L0 + 8'(4 * g), efc_pkg::LATCH_RESET, OK);
			rd(C0 + 8'(4 * g), 32'h0, OK);
			rd(S0 + 8'(4 * g), 32'h0, OK);
		end
		$display("test reset values done");
		fire_evt(7'h05);
		rd(L0, 32'h20, OK);
		sel(4'h1);
		wr(L0, 32'h0, OK);
		wr(C0, 32'h0, OK);
		rd(L0, 32'h20, OK);
		sel(4'h1);
		wr(C0, 32'h20, OK);
		tick(2);
		rd(L0, 32'h0, OK);
		sel(4'h0);
		fire <= 1'h1;
		idx <= 7'h06;
		@(posedge mclk);
		fire <= 1'h0;
		tick(4);
		wr(C0, 32'h40, OK);
		rd(L0, 32'h40, OK);
		wr(C0, 32'h40, OK);
		rd(L0, 32'h0, OK);
		$display("test latch and clear done");
		fire_evt(7'h64);
		rd(L0 + 8'hC, 32'h10, OK);
		sel(4'h8);
		wr(S0 + 8'h8, 32'h80, OK);
		tick(2);
		rd(L0 + 8'h8, 32'h80, OK);
		sel(4'hC);
		wr(M0 + 8'h8, 32'h80, OK);
		tick(2);
		sel(4'h8);
		rd(M0 + 8'h8, 32'h80, OK);
		s_axi_wstrb <= 4'h2;
		wr(M0 + 8'h4, 32'hFFFFFFFF, OK);
		s_axi_wstrb <= 4'hF;
		rd(M0 + 8'h4, 32'h0000FF00, OK);
		wr(S0, 32'hF, OK);
		tick(2);
		rd(L0, 32'h0, OK);
		sel(4'h8);
		$display("test set and mask done");
		rd(efc_pkg::OFS_IRQ_STAT, 32'hD, OK);
		irqchk(1'h0);
		wr(efc_pkg::OFS_IRQ_MASK, 32'h4, OK);
		tick(2);
		irqchk(1'h1);
		wr(efc_pkg::OFS_IRQ_STAT, 32'h4, OK);
		tick(2);
		irqchk(1'h0);
		rd(efc_pkg::OFS_IRQ_STAT, 32'h9, OK);
		rd(efc_pkg::OFS_IRQ_MASK, 32'h4, OK);
		wr(8'h48, 32'h0, efc_pkg::RESP_SLVERR);
		rd(8'h4C, 32'h0, efc_pkg::RESP_SLVERR);
		$display("test interrupt and unmapped done");
		final_report();
	end
endmodule
